//--- include/panel_map.svh
// panel_map.svh: constants for the front-panel menu controller.
// assumes inclusion by both design files and the bench.
`ifndef PANEL_MAP_SVH
`define PANEL_MAP_SVH

`define CLK_HZ 50_000_000
`define LIGHT_MIN 10
`define LIGHT_CYCLES (64'(`LIGHT_MIN) * 60 * `CLK_HZ)
`define SPLASH_MS 3000
`define SPLASH_CYCLES (`SPLASH_MS * (`CLK_HZ / 1000))
`define FLASH_HALF_MS 250
`define FLASH_HALF_CYCLES (`FLASH_HALF_MS * (`CLK_HZ / 1000))
`define MASTER_CODE 16'h2301
`define PW_DIGITS 4
`define DIGIT_MAX 4'h9
`define LANG_ENGLISH 3'h1
`define LANG_COUNT 3'h5
`define ITEM_COUNT 3'h6
`define PAR_COUNT 3'h5

`endif

//--- include/panel_pkg.sv
// panel_pkg.sv: types shared by the panel controller.
// assumes panel_map.svh defines the numeric constants.
package panel_pkg;
  typedef enum logic [1:0] {
    led_off,
    led_green,
    led_orange
  } led_t;

  typedef enum logic [3:0] {
    st_splash,
    st_measure,
    st_main,
    st_view,
    st_param,
    st_lang,
    st_opt_enable,
    st_opt_pwact,
    st_opt_pnact,
    st_pw_entry,
    st_pw_prompt
  } menu_t;

  // top-level main menu items
  typedef enum logic [2:0] {
    m_devinfo,
    m_netinfo,
    m_status,
    m_param,
    m_lang,
    m_service
  } main_item_t;
endpackage

//--- design/link_led.sv
// link_led.sv: one port link led driver, steady green on link, orange flash on activity.
// assumes link and activity inputs are synchronous to i_clock.
`timescale 1ns/1ns
`include "panel_map.svh"
module link_led #(
  parameter int FLASH_HALF = `FLASH_HALF_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_link,
  input wire logic i_activity,
  output panel_pkg::led_t o_led,
  output logic o_link_flag
);
  logic [24:0] cnt_reg, cnt_next;
  logic phase_reg, phase_next;
  panel_pkg::led_t led_reg, led_next;
  logic flag_reg, flag_next;

  always_comb begin
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    if (cnt_reg >= 25'(FLASH_HALF - 1)) begin
      cnt_next = 25'h000_0000;
      phase_next = ~phase_reg;
    end else begin
      cnt_next = cnt_reg + 25'h000_0001;
    end
    // led and display flag come from the same link term, cleared next cycle on loss
    flag_next = i_link;
    if (!i_link) begin
      led_next = panel_pkg::led_off;
    end else if (i_activity) begin
      led_next = phase_reg ? panel_pkg::led_orange : panel_pkg::led_off;
    end else begin
      led_next = panel_pkg::led_green;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 25'h000_0000;
      phase_reg <= 1'b0;
      led_reg <= panel_pkg::led_off;
      flag_reg <= 1'b0;
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      led_reg <= led_next;
      flag_reg <= flag_next;
    end
  end

  assign o_led = led_reg;
  assign o_link_flag = flag_reg;

  a_link_green: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_link && !i_activity |=> o_led == panel_pkg::led_green)
    else $error("link without activity not green");
  a_led_matches_flag: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_led != panel_pkg::led_green) || o_link_flag)
    else $error("green led without link flag");
  a_link_loss_clears: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && !i_link |=> !o_link_flag && o_led == panel_pkg::led_off)
    else $error("link loss not cleared");
  a_activity_flash: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_link && i_activity |=> o_led != panel_pkg::led_green)
    else $error("activity shown green");
endmodule

//--- design/panel_ctrl.sv
// panel_ctrl.sv: front-panel menu, parameter enabling, password and led controller.
// assumes buttons are one-cycle synchronous pulses already debounced.
//
// How it works
// - bus led flashes orange while node identification runs.
// - port link led steady green while its physical link exists.
// - each link led agrees with the link flag shown on the display.
// - link led flashes orange while frames move on that port.
// - up and down step to previous or next item at current level.
// - enter descends into or confirms the selected item.
// - escape returns exactly one menu level upward.
// - any button lights the display for ten minutes after last press.
// - value entry composes digits; save with enter stores the value.
// - step-back with enter discards the last digit.
// - in option lists enter makes highlighted option active.
// - identification screen for seconds, then measurement window.
// - information, status and service menus ignore edits.
// - local enabling defaults off; on inverts display, allows edits.
// - enabling on drops network participation until switched off.
// - network parameter set kept aside while local edits apply.
// - enabling off rejoins; controller download overwrites local edits.
// - password activation only while enabled; set password locks changes.
// - password is four decimal digits via value entry.
// - master code grants access regardless of user password.
// - reset to defaults restores factory values and English at once.
// - participant activation defaults on; off keeps switch forwarding.
// - bus led steady green while cyclic exchange runs with participation on and enabling off.
`timescale 1ns/1ns
`include "panel_map.svh"
module panel_ctrl #(
  parameter longint LIGHT_TIME = `LIGHT_CYCLES,
  parameter int SPLASH_TIME = `SPLASH_CYCLES,
  parameter int FLASH_HALF = `FLASH_HALF_CYCLES,
  parameter int PAR_W = 16
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_btn_up,
  input wire logic i_btn_down,
  input wire logic i_btn_enter,
  input wire logic i_btn_esc,
  input wire logic i_port_in_link,
  input wire logic i_port_out_link,
  input wire logic i_port_in_activity,
  input wire logic i_port_out_activity,
  input wire logic i_wave_active,
  input wire logic i_data_exchange,
  input wire logic i_net_par_valid,
  input wire logic [PAR_W-1:0] i_net_par,
  output panel_pkg::led_t o_bus_led,
  output panel_pkg::led_t o_port_in_led,
  output panel_pkg::led_t o_port_out_led,
  output logic o_port_in_link_flag,
  output logic o_port_out_link_flag,
  output logic o_backlight,
  output logic o_display_inverted,
  output panel_pkg::menu_t o_menu,
  output logic [2:0] o_cursor,
  output logic o_participant_en,
  output logic o_switch_forward,
  output logic [PAR_W-1:0] o_work_par,
  output logic [2:0] o_language,
  output logic o_pw_locked
);
  // ---------------------------------------------------------------
  // port link leds
  // ---------------------------------------------------------------
  link_led #(.FLASH_HALF(FLASH_HALF)) u_in_led (
    .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
    .i_link(i_port_in_link), .i_activity(i_port_in_activity),
    .o_led(o_port_in_led), .o_link_flag(o_port_in_link_flag)
  );
  link_led #(.FLASH_HALF(FLASH_HALF)) u_out_led (
    .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
    .i_link(i_port_out_link), .i_activity(i_port_out_activity),
    .o_led(o_port_out_led), .o_link_flag(o_port_out_link_flag)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic any_btn;
  assign any_btn = i_btn_up | i_btn_down | i_btn_enter | i_btn_esc;

  panel_pkg::menu_t menu_reg, menu_next;
  logic [2:0] cur_reg, cur_next;
  logic [31:0] timer_reg, timer_next;
  logic [35:0] light_reg, light_next;
  logic lit_reg, lit_next;
  logic enable_reg, enable_next;
  logic pwact_reg, pwact_next;
  logic pnact_reg, pnact_next;
  logic unlocked_reg, unlocked_next;
  logic [15:0] pw_reg, pw_next;
  logic [15:0] entry_reg, entry_next;
  logic [2:0] ndig_reg, ndig_next;
  logic [3:0] digit_reg, digit_next;
  logic pw_set_mode_reg, pw_set_mode_next;
  logic [PAR_W-1:0] net_reg, net_next;
  logic [PAR_W-1:0] work_reg, work_next;
  logic [2:0] lang_reg, lang_next;
  logic [24:0] fl_reg, fl_next;
  logic ph_reg, ph_next;
  panel_pkg::led_t bus_reg, bus_next;
  logic part_reg, part_next;
  logic lock_reg, lock_next;
  logic edit_ok;
  logic [2:0] n_items;

  // edits need local enabling and, with a password active, a valid entry
  assign edit_ok = enable_reg && (!pwact_reg || unlocked_reg);

  // ---------------------------------------------------------------
  // menu and parameter logic
  // ---------------------------------------------------------------
  always_comb begin
    menu_next = menu_reg;
    cur_next = cur_reg;
    timer_next = timer_reg;
    enable_next = enable_reg;
    pwact_next = pwact_reg;
    pnact_next = pnact_reg;
    unlocked_next = unlocked_reg;
    pw_next = pw_reg;
    entry_next = entry_reg;
    ndig_next = ndig_reg;
    digit_next = digit_reg;
    pw_set_mode_next = pw_set_mode_reg;
    net_next = net_reg;
    work_next = work_reg;
    lang_next = lang_reg;
    n_items = (menu_reg == panel_pkg::st_main) ? `ITEM_COUNT :
              (menu_reg == panel_pkg::st_param) ? `PAR_COUNT : `LANG_COUNT;
    // network set always tracked; working set follows it only when on-line
    if (i_net_par_valid) begin
      net_next = i_net_par;
      if (!enable_reg) begin
        work_next = i_net_par;
      end
    end
    case (menu_reg)
      panel_pkg::st_splash: begin
        if (timer_reg >= 32'(SPLASH_TIME - 1)) begin
          menu_next = panel_pkg::st_measure;
          timer_next = 32'h0000_0000;
        end else begin
          timer_next = timer_reg + 32'h0000_0001;
        end
      end
      panel_pkg::st_measure: begin
        if (i_btn_enter) begin
          menu_next = panel_pkg::st_main;
          cur_next = 3'h0;
        end
      end
      panel_pkg::st_main, panel_pkg::st_param, panel_pkg::st_lang: begin
        if (i_btn_up) begin
          cur_next = (cur_reg == 3'h0) ? n_items - 3'h1 : cur_reg - 3'h1;
        end else if (i_btn_down) begin
          cur_next = (cur_reg == n_items - 3'h1) ? 3'h0 : cur_reg + 3'h1;
        end else if (i_btn_esc) begin
          // one level up: submenus to main, main to measurement
          menu_next = (menu_reg == panel_pkg::st_main) ? panel_pkg::st_measure : panel_pkg::st_main;
          cur_next = (menu_reg == panel_pkg::st_param) ? 3'(panel_pkg::m_param) :
                     (menu_reg == panel_pkg::st_lang) ? 3'(panel_pkg::m_lang) : 3'h0;
        end else if (i_btn_enter) begin
          cur_next = 3'h0;
          if (menu_reg == panel_pkg::st_lang) begin
            lang_next = cur_reg;
            menu_next = panel_pkg::st_main;
            cur_next = 3'(panel_pkg::m_lang);
          end else if (menu_reg == panel_pkg::st_main) begin
            if (cur_reg == 3'(panel_pkg::m_param)) begin
              menu_next = panel_pkg::st_param;
            end else if (cur_reg == 3'(panel_pkg::m_lang)) begin
              menu_next = panel_pkg::st_lang;
              cur_next = lang_reg;
            end else begin
              menu_next = panel_pkg::st_view;
            end
          end else if (cur_reg == 3'h0) begin
            menu_next = panel_pkg::st_opt_enable;
            cur_next = {2'h0, enable_reg};
          end else if (cur_reg == 3'h1) begin
            menu_next = panel_pkg::st_opt_pwact;
            cur_next = {2'h0, pwact_reg};
          end else if (cur_reg == 3'h2) begin
            if (edit_ok) begin
              menu_next = panel_pkg::st_pw_entry;
              pw_set_mode_next = 1'b1;
              entry_next = 16'h0000;
              ndig_next = 3'h0;
              digit_next = 4'h0;
            end
          end else if (cur_reg == 3'h3) begin
            if (edit_ok) begin
              // factory values at once, no prompt
              work_next = '0;
              lang_next = `LANG_ENGLISH;
              pnact_next = 1'b1;
              pwact_next = 1'b0;
            end
            cur_next = 3'h3;
          end else begin
            menu_next = panel_pkg::st_opt_pnact;
            cur_next = {2'h0, pnact_reg};
          end
        end
      end
      panel_pkg::st_view: begin
        // read-only pages: only escape has an effect
        if (i_btn_esc) begin
          menu_next = panel_pkg::st_main;
        end
      end
      panel_pkg::st_opt_enable, panel_pkg::st_opt_pwact, panel_pkg::st_opt_pnact: begin
        if (i_btn_up || i_btn_down) begin
          cur_next = {2'h0, ~cur_reg[0]};
        end else if (i_btn_esc) begin
          menu_next = panel_pkg::st_param;
          cur_next = 3'h0;
        end else if (i_btn_enter) begin
          menu_next = panel_pkg::st_param;
          cur_next = 3'h0;
          if (menu_reg == panel_pkg::st_opt_enable) begin
            if (cur_reg[0] && pwact_reg && !unlocked_reg) begin
              enable_next = 1'b1;
              menu_next = panel_pkg::st_pw_prompt;
              pw_set_mode_next = 1'b0;
              entry_next = 16'h0000;
              ndig_next = 3'h0;
              digit_next = 4'h0;
            end else begin
              enable_next = cur_reg[0];
              if (!cur_reg[0]) begin
                unlocked_next = 1'b0;
                work_next = net_reg;
              end
            end
          end else if (menu_reg == panel_pkg::st_opt_pwact) begin
            if (edit_ok) begin
              pwact_next = cur_reg[0];
            end
          end else if (edit_ok) begin
            pnact_next = cur_reg[0];
          end
        end
      end
      panel_pkg::st_pw_entry, panel_pkg::st_pw_prompt: begin
        // cursor 0 digit, 1 step back, 2 save
        if (i_btn_up) begin
          if (cur_reg == 3'h0) begin
            digit_next = (digit_reg == `DIGIT_MAX) ? 4'h0 : digit_reg + 4'h1;
          end
          cur_next = (cur_reg == 3'h0) ? 3'h2 : cur_reg - 3'h1;
        end else if (i_btn_down) begin
          cur_next = (cur_reg == 3'h2) ? 3'h0 : cur_reg + 3'h1;
        end else if (i_btn_esc) begin
          menu_next = panel_pkg::st_param;
          cur_next = 3'h0;
        end else if (i_btn_enter) begin
          if (cur_reg == 3'h0 && ndig_reg < 3'(`PW_DIGITS)) begin
            entry_next = {entry_reg[11:0], digit_reg};
            ndig_next = ndig_reg + 3'h1;
            digit_next = 4'h0;
          end else if (cur_reg == 3'h1 && ndig_reg != 3'h0) begin
            entry_next = {4'h0, entry_reg[15:4]};
            ndig_next = ndig_reg - 3'h1;
          end else if (cur_reg == 3'h2 && ndig_reg == 3'(`PW_DIGITS)) begin
            cur_next = 3'h0;
            entry_next = 16'h0000;
            ndig_next = 3'h0;
            if (pw_set_mode_reg) begin
              pw_next = entry_reg;
              menu_next = panel_pkg::st_param;
            end else if (entry_reg == pw_reg || entry_reg == `MASTER_CODE) begin
              unlocked_next = 1'b1;
              menu_next = panel_pkg::st_param;
            end else begin
              unlocked_next = 1'b0;
            end
          end
        end
      end
      default: menu_next = panel_pkg::st_splash;
    endcase
    // registered so these outputs leave straight from flops
    part_next = pnact_next & ~enable_next;
    lock_next = pwact_next & ~unlocked_next;
  end

  // ---------------------------------------------------------------
  // illumination and bus led
  // ---------------------------------------------------------------
  always_comb begin
    light_next = light_reg;
    lit_next = lit_reg;
    if (any_btn) begin
      light_next = 36'h0_0000_0000;
      lit_next = 1'b1;
    end else if (lit_reg) begin
      if (light_reg >= 36'(LIGHT_TIME - 1)) begin
        lit_next = 1'b0;
      end else begin
        light_next = light_reg + 36'h0_0000_0001;
      end
    end
    fl_next = (fl_reg >= 25'(FLASH_HALF - 1)) ? 25'h000_0000 : fl_reg + 25'h000_0001;
    ph_next = (fl_reg >= 25'(FLASH_HALF - 1)) ? ~ph_reg : ph_reg;
    if (i_wave_active) begin
      bus_next = ph_reg ? panel_pkg::led_orange : panel_pkg::led_off;
    end else if (enable_reg || !pnact_reg) begin
      bus_next = panel_pkg::led_off;
    end else if (i_data_exchange) begin
      bus_next = panel_pkg::led_green;
    end else begin
      bus_next = ph_reg ? panel_pkg::led_green : panel_pkg::led_off;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      menu_reg <= panel_pkg::st_splash;
      cur_reg <= 3'h0;
      timer_reg <= 32'h0000_0000;
      light_reg <= 36'h0_0000_0000;
      lit_reg <= 1'b1;
      enable_reg <= 1'b0;
      pwact_reg <= 1'b0;
      pnact_reg <= 1'b1;
      unlocked_reg <= 1'b0;
      pw_reg <= 16'h0000;
      entry_reg <= 16'h0000;
      ndig_reg <= 3'h0;
      digit_reg <= 4'h0;
      pw_set_mode_reg <= 1'b0;
      net_reg <= '0;
      work_reg <= '0;
      lang_reg <= `LANG_ENGLISH;
      fl_reg <= 25'h000_0000;
      ph_reg <= 1'b0;
      bus_reg <= panel_pkg::led_off;
      part_reg <= 1'b1;
      lock_reg <= 1'b0;
    end else if (i_ce) begin
      menu_reg <= menu_next;
      cur_reg <= cur_next;
      timer_reg <= timer_next;
      light_reg <= light_next;
      lit_reg <= lit_next;
      enable_reg <= enable_next;
      pwact_reg <= pwact_next;
      pnact_reg <= pnact_next;
      unlocked_reg <= unlocked_next;
      pw_reg <= pw_next;
      entry_reg <= entry_next;
      ndig_reg <= ndig_next;
      digit_reg <= digit_next;
      pw_set_mode_reg <= pw_set_mode_next;
      net_reg <= net_next;
      work_reg <= work_next;
      lang_reg <= lang_next;
      fl_reg <= fl_next;
      ph_reg <= ph_next;
      bus_reg <= bus_next;
      part_reg <= part_next;
      lock_reg <= lock_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops except the constant switch forward
  // ---------------------------------------------------------------
  assign o_bus_led = bus_reg;
  assign o_backlight = lit_reg;
  assign o_display_inverted = enable_reg;
  assign o_menu = menu_reg;
  assign o_cursor = cur_reg;
  assign o_participant_en = part_reg;
  assign o_switch_forward = 1'b1;
  assign o_work_par = work_reg;
  assign o_language = lang_reg;
  assign o_pw_locked = lock_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_param_enter;
    i_ce && menu_reg == panel_pkg::st_main && cur_reg == 3'(panel_pkg::m_param) && i_btn_enter && !i_btn_up
      && !i_btn_down && !i_btn_esc;
  endsequence

  a_wave_orange: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_wave_active |=> o_bus_led != panel_pkg::led_green)
    else $error("bus led green during wave");
  a_enter_descend: assert property (@(posedge i_clock) disable iff (i_rst)
    s_param_enter |=> o_menu == panel_pkg::st_param && o_cursor == 3'h0)
    else $error("enter did not descend");
  a_esc_one_up: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && menu_reg == panel_pkg::st_param && i_btn_esc && !i_btn_up && !i_btn_down
      |=> o_menu == panel_pkg::st_main)
    else $error("escape not one level up");
  a_light_restart: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && any_btn |=> o_backlight && light_reg == 36'h0_0000_0000)
    else $error("backlight not restarted");
  a_view_no_edit: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && menu_reg == panel_pkg::st_view |=> $stable(enable_reg) && $stable(pw_reg))
    else $error("view menu changed settings");
  a_offline_enabled: assert property (@(posedge i_clock) disable iff (i_rst)
    enable_reg |-> !o_participant_en && o_display_inverted)
    else $error("still on network while enabled");
  a_wrong_pw: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && menu_reg == panel_pkg::st_pw_prompt && i_btn_enter && cur_reg == 3'h2 && ndig_reg == 3'h4
      && entry_reg != pw_reg && entry_reg != `MASTER_CODE && !i_btn_up && !i_btn_down && !i_btn_esc
      |=> o_menu == panel_pkg::st_pw_prompt && o_pw_locked)
    else $error("wrong password accepted");
  a_master_code: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && menu_reg == panel_pkg::st_pw_prompt && i_btn_enter && cur_reg == 3'h2 && ndig_reg == 3'h4
      && entry_reg == `MASTER_CODE && !i_btn_up && !i_btn_down && !i_btn_esc |=> unlocked_reg)
    else $error("master code refused");
  a_exchange_green: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ce && i_data_exchange && !i_wave_active && pnact_reg && !enable_reg
      |=> o_bus_led == panel_pkg::led_green)
    else $error("bus led not green in exchange");
endmodule

//--- dv/net_partner.sv
// net_partner.sv: network side, random frame traffic and parameter downloads.
// assumes the panel controller's clock and reset.
`timescale 1ns/1ns
module net_partner (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_quiet,
  input wire logic i_joined,
  output logic o_in_act,
  output logic o_out_act,
  output logic o_par_valid,
  output logic [15:0] o_par,
  output logic [15:0] o_last_par
);
  logic [31:0] lfsr_reg;
  logic joined_reg;
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lfsr_reg <= 32'h0000_d323;
      joined_reg <= 1'b0;
      o_in_act <= 1'b0;
      o_out_act <= 1'b0;
      o_par_valid <= 1'b0;
      o_par <= 16'h0000;
      o_last_par <= 16'h0000;
    end else begin
      lfsr_reg <= step(lfsr_reg);
      joined_reg <= i_joined;
      o_in_act <= ~i_quiet & lfsr_reg[0];
      o_out_act <= ~i_quiet & lfsr_reg[3];
      // full set on rejoin, silent while cut off
      o_par_valid <= i_joined & (~joined_reg | (lfsr_reg[4:0] == 5'h00));
      o_par <= lfsr_reg[31:16];
      if (o_par_valid) o_last_par <= o_par;
    end
  end
endmodule

//--- dv/tb_top.sv
// tb_top.sv: self-checking bench for the panel controller.
// assumes net_partner plays the network controller.
`timescale 1ns/1ns
`include "panel_map.svh"
module tb_top;
  logic clk = 1'b0, rst = 1'b1, quiet = 1'b1, lk = 1'b0, wave = 1'b0, exch = 1'b0, ce = 1'b1;
  logic [3:0] btn = 4'h0;
  logic ia, oa, pv, iflag, oflag, bl, inv, pe, fwd, lock;
  logic [15:0] par, last, wp;
  logic [2:0] cur, lang;
  panel_pkg::led_t bus, il, ol;
  panel_pkg::menu_t menu;
  int n_errors = 0, checks = 0;
  always #10 clk = ~clk;
  net_partner p_u (.i_clock(clk), .i_rst(rst), .i_quiet(quiet), .i_joined(pe), .o_in_act(ia),
    .o_out_act(oa), .o_par_valid(pv), .o_par(par), .o_last_par(last));
  panel_ctrl #(.LIGHT_TIME(200), .SPLASH_TIME(20), .FLASH_HALF(4)) dut_u (.i_clock(clk), .i_rst(rst),
    .i_ce(ce), .i_btn_up(btn[3]), .i_btn_down(btn[2]), .i_btn_enter(btn[1]), .i_btn_esc(btn[0]),
    .i_port_in_link(lk), .i_port_out_link(lk), .i_port_in_activity(ia), .i_port_out_activity(oa),
    .i_wave_active(wave), .i_data_exchange(exch), .i_net_par_valid(pv), .i_net_par(par),
    .o_bus_led(bus), .o_port_in_led(il), .o_port_out_led(ol), .o_port_in_link_flag(iflag),
    .o_port_out_link_flag(oflag), .o_backlight(bl), .o_display_inverted(inv), .o_menu(menu),
    .o_cursor(cur), .o_participant_en(pe), .o_switch_forward(fwd), .o_work_par(wp),
    .o_language(lang), .o_pw_locked(lock));
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic cmp_bit(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_val(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // index: 3 up, 2 down, 1 enter, 0 escape
  task automatic press(input int b);
    @(posedge clk) btn[b] <= 1'b1;
    @(posedge clk) btn[b] <= 1'b0;
    @(negedge clk);
  endtask
  task automatic go(input logic [2:0] c);
    for (int i = 0; i < 8 && cur !== c; i++) press(2);
  endtask
  // option pages open on the current value, so one down flips it
  task automatic flip;
    press(1);
    press(2);
    press(1);
  endtask
  // up on the digit also jumps the cursor to save, down brings it back
  task automatic key(input logic [3:0] d);
    repeat (d) begin
      press(3);
      press(2);
    end
    press(1);
  endtask
  task automatic code(input logic [15:0] c);
    for (int i = 3; i >= 0; i--) key(c[4*i +: 4]);
    press(2);
    press(2);
    press(1);
  endtask
  task automatic watch_orange(input logic sel);
    logic seen;
    seen = 1'b0;
    repeat (16) begin
      @(negedge clk);
      seen |= ((sel ? bus : il) === panel_pkg::led_orange);
    end
    cmp_bit(seen, 1'b1);
  endtask
  function automatic logic [2:0] up_of(input logic [2:0] c);
    return (c == 3'h0) ? `ITEM_COUNT - 3'h1 : c - 3'h1;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    #200000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp_bit(inv, 1'b0);
    cmp_bit(pe, 1'b1);
    cmp_bit(fwd, 1'b1);
    repeat (10) @(negedge clk);
    cmp_val(menu, panel_pkg::st_splash);
    repeat (14) @(negedge clk);
    cmp_val(menu, panel_pkg::st_measure);
    $display("test power_up done");
    @(posedge clk) lk <= 1'b1;
    repeat (3) @(negedge clk);
    cmp_bit(iflag, 1'b1);
    cmp_bit(oflag, 1'b1);
    cmp_val(il, panel_pkg::led_green);
    cmp_val(ol, panel_pkg::led_green);
    @(posedge clk) quiet <= 1'b0;
    watch_orange(1'b0);
    @(posedge clk) lk <= 1'b0;
    quiet <= 1'b1;
    repeat (3) @(negedge clk);
    cmp_bit(iflag, 1'b0);
    cmp_val(ol, panel_pkg::led_off);
    $display("test links done");
    press(1);
    cmp_val(menu, panel_pkg::st_main);
    press(3);
    cmp_val(cur, up_of(3'h0));
    press(2);
    cmp_val(cur, 3'h0);
    press(1);
    press(3);
    press(1);
    cmp_val(menu, panel_pkg::st_view);
    cmp_bit(inv, 1'b0);
    press(0);
    cmp_val(menu, panel_pkg::st_main);
    go(3'h3);
    press(1);
    cmp_val(menu, panel_pkg::st_param);
    press(1);
    press(2);
    press(1);
    cmp_val(menu, panel_pkg::st_param);
    cmp_bit(inv, 1'b1);
    repeat (20) @(negedge clk);
    cmp_bit(pe, 1'b0);
    press(0);
    press(2);
    press(1);
    press(2);
    press(1);
    cmp_val(lang, 3'h2);
    press(3);
    press(1);
    go(3'h3);
    press(1);
    cmp_val(lang, `LANG_ENGLISH);
    cmp_val(wp, 16'h0000);
    go(3'h2);
    press(1);
    key(4'h1);
    key(4'h5);
    press(2);
    press(1);
    press(3);
    key(4'h2);
    key(4'h0);
    key(4'h3);
    press(2);
    press(2);
    press(1);
    cmp_val(menu, panel_pkg::st_param);
    go(3'h1);
    flip;
    cmp_bit(lock, 1'b1);
    go(3'h1);
    flip;
    cmp_bit(lock, 1'b1);
    flip;
    flip;
    cmp_val(menu, panel_pkg::st_pw_prompt);
    code(16'h0000);
    cmp_val(menu, panel_pkg::st_pw_prompt);
    cmp_bit(lock, 1'b1);
    code(16'h1203);
    cmp_bit(lock, 1'b0);
    flip;
    flip;
    code(16'h2301);
    cmp_bit(lock, 1'b0);
    $display("test password done");
    go(3'h0);
    press(1);
    go(3'h0);
    press(1);
    cmp_bit(pe, 1'b1);
    cmp_val(wp, last);
    repeat (4) @(negedge clk);
    cmp_val(wp, last);
    $display("test enabling done");
    @(posedge clk) exch <= 1'b1;
    repeat (3) @(negedge clk);
    cmp_val(bus, panel_pkg::led_green);
    @(posedge clk) wave <= 1'b1;
    watch_orange(1'b1);
    @(posedge clk) ce <= 1'b0;
    press(2);
    cmp_val(cur, 3'h0);
    @(posedge clk) ce <= 1'b1;
    repeat (210) @(negedge clk);
    cmp_bit(bl, 1'b0);
    press(0);
    cmp_bit(bl, 1'b1);
    $display("test leds_light done");
    complete_run;
  end
endmodule
